// File: cmc_pkg.sv
// Purpose: constants for the CAN operating-mode control block
// Assumes: AXI4-Lite register access, 32-bit words
// Notes:   offsets are byte addresses
package cmc_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] MASTER_CTRL   = 12'h000;
  localparam logic [11:0] MODE_STATUS   = 12'h004;
  localparam logic [31:0] MCTRL_RESET   = 32'h0001_0002;
  localparam logic [31:0] MCTRL_RW_MASK = 32'h0001_00ff;
  // ****************************************************************
  // master control fields
  // ****************************************************************
  localparam int BIT_FREEZE   = 0;
  localparam int BIT_SLEEP    = 1;
  localparam int BIT_TXORDER  = 2;
  localparam int BIT_DISCARD  = 3;
  localparam int BIT_NORETRY  = 4;
  localparam int BIT_AUTOWAKE = 5;
  localparam int BIT_AUTOREC  = 6;
  localparam int BIT_TTEN     = 7;
  localparam int BIT_PARTIAL_SOFT_RESET    = 15;
  localparam int BIT_PTD      = 16;
  // ****************************************************************
  // mode status fields
  // ****************************************************************
  localparam int STS_FREEZE = 0;
  localparam int STS_SLEEP  = 1;
  localparam int STS_BUSOFF = 2;
  localparam int STS_RX     = 3;
  // ****************************************************************
  // bus timing and axi response codes
  // ****************************************************************
  localparam logic [3:0] RECESSIVE_LAST = 4'd10;   // 11 bits
  localparam logic [7:0] OCC_LAST       = 8'd127;  // 128 runs
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;
endpackage : cmc_pkg

// File: cmc_mode_ctrl.sv
// Purpose: operating-mode control of a CAN controller, AXI4-Lite slave
// Assumes: canRx is asynchronous; busActive, busOffEnter, frameStart
//          come from protocol logic on mclk
// Notes:   one write and one read outstanding at a time
`timescale 1ns/1ps
`default_nettype none

module cmc_mode_ctrl #(
  parameter int BIT_CYCLES = 50
) (
  // clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // axi4-lite write
  input  wire logic [cmc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output var  logic                      s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output var  logic                      s_axi_wready,
  output var  logic [1:0]                s_axi_bresp,
  output var  logic                      s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read
  input  wire logic [cmc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output var  logic                      s_axi_arready,
  output var  logic [31:0]               s_axi_rdata,
  output var  logic [1:0]                s_axi_rresp,
  output var  logic                      s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // can bus and protocol engine
  input  wire logic                      canRx,
  input  wire logic                      busActive,
  input  wire logic                      busOffEnter,
  input  wire logic                      frameStart,
  // mode outputs
  output var  logic                      timeTrigEnable,
  output var  logic                      noRetryOnFail,
  output var  logic                      overflowDiscardSelect,
  output var  logic                      txOrderSelect,
  output var  logic                      prohibitTxDebug,
  output var  logic                      sleepMode,
  output var  logic                      freezeMode,
  output var  logic                      busOff,
  output var  logic                      rxFifoReset
);
  import cmc_pkg::*;

  typedef struct packed {
    logic              awRdy;
    logic              wRdy;
    logic              awTaken;
    logic [ADDR_W-1:0] awAddr;
    logic              wTaken;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arRdy;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
    logic [31:0]       ctrl;
    logic              sleeping;
    logic              frozen;
    logic              busOff;
    logic              seenFreeze;
    logic              recArmed;
    logic              fifoRst;
    logic              rxMeta;
    logic              rxSync;
    logic [15:0]       bitCnt;
    logic [3:0]        recCnt;
    logic [7:0]        occCnt;
  } cmc_state_s;

  cmc_state_s st;
  cmc_state_s next_st;
  logic       run11;
  logic       commit;
  logic       wrOk;

  function automatic logic [31:0] cmc_read(input logic [ADDR_W-1:0] a,
                                           input cmc_state_s s);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == MASTER_CTRL) begin
      v = s.ctrl & MCTRL_RW_MASK;
    end else if (a == MODE_STATUS) begin
      v[STS_FREEZE] = s.frozen;
      v[STS_SLEEP]  = s.sleeping;
      v[STS_BUSOFF] = s.busOff;
      v[STS_RX]     = s.rxSync;
    end
    return v;
  endfunction : cmc_read

  function automatic logic cmc_mapped(input logic [ADDR_W-1:0] a);
    return (a == MASTER_CTRL) || (a == MODE_STATUS);
  endfunction : cmc_mapped

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.fifoRst = 1'b0;
    // second flop only: first flop feeds nothing else
    next_st.rxMeta = canRx;
    next_st.rxSync = st.rxMeta;

    // recessive bit timing on the synchronised pin
    run11   = 1'b0;
    if (!st.rxSync) begin
      next_st.bitCnt = 16'h0000;
      next_st.recCnt = 4'h0;
    end else if (st.bitCnt == 16'(BIT_CYCLES - 1)) begin
      next_st.bitCnt = 16'h0000;
      if (st.recCnt == RECESSIVE_LAST) begin
        run11          = 1'b1;
        next_st.recCnt = 4'h0;
      end else begin
        next_st.recCnt = st.recCnt + 4'h1;
      end
    end else begin
      next_st.bitCnt = st.bitCnt + 16'h0001;
    end

    // axi write channels, taken in either order
    if (s_axi_awvalid && st.awRdy) begin
      next_st.awTaken = 1'b1;
      next_st.awAddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wRdy) begin
      next_st.wTaken = 1'b1;
      next_st.wData  = s_axi_wdata;
      next_st.wStrb  = s_axi_wstrb;
    end
    commit = st.awTaken && st.wTaken && !st.bValid;
    // partial word writes are refused, the register expects words
    wrOk = cmc_mapped(st.awAddr) && (st.wStrb == 4'hf);
    if (commit) begin
      next_st.awTaken = 1'b0;
      next_st.wTaken  = 1'b0;
      next_st.bValid  = 1'b1;
      next_st.bResp   = wrOk ? RESP_OKAY : RESP_SLVERR;
      if (wrOk && st.awAddr == MASTER_CTRL) begin
        next_st.ctrl = st.wData & MCTRL_RW_MASK;
        if (st.wData[BIT_PARTIAL_SOFT_RESET]) begin
          next_st.ctrl    = MCTRL_RESET;
          next_st.fifoRst = 1'b1;
        end
      end
    end else if (st.bValid && s_axi_bready) begin
      next_st.bValid = 1'b0;
    end

    // axi read
    if (s_axi_arvalid && st.arRdy) begin
      next_st.rValid = 1'b1;
      next_st.rData  = cmc_read(s_axi_araddr, st);
      next_st.rResp  = cmc_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st.rValid && s_axi_rready) begin
      next_st.rValid = 1'b0;
    end

    // auto wake clears the request; hardware clear beats a write
    if (st.sleeping && st.ctrl[BIT_AUTOWAKE] && frameStart) begin
      next_st.ctrl[BIT_SLEEP] = 1'b0;
    end
    next_st.sleeping = next_st.ctrl[BIT_SLEEP];

    // freeze entry waits for idle bus, exit for 11 recessive bits
    if (!st.frozen && st.ctrl[BIT_FREEZE] && !busActive) begin
      next_st.frozen = 1'b1;
    end else if (st.frozen && !st.ctrl[BIT_FREEZE] && run11) begin
      next_st.frozen = 1'b0;
    end

    // bus-off recovery
    if (busOffEnter) begin
      next_st.busOff     = 1'b1;
      next_st.seenFreeze = 1'b0;
      next_st.recArmed   = 1'b0;
      next_st.occCnt     = 8'h00;
    end else if (st.busOff) begin
      if (st.frozen) begin
        next_st.seenFreeze = 1'b1;
      end
      if (st.seenFreeze && !st.frozen) begin
        next_st.recArmed = 1'b1;
      end
      if ((st.ctrl[BIT_AUTOREC] || st.recArmed) && run11) begin
        if (st.occCnt == OCC_LAST) begin
          next_st.busOff = 1'b0;
        end else begin
          next_st.occCnt = st.occCnt + 8'h01;
        end
      end
    end

    // ready flags stay low while a transfer is held
    next_st.awRdy = !next_st.awTaken && !next_st.bValid;
    next_st.wRdy  = !next_st.wTaken && !next_st.bValid;
    next_st.arRdy = !next_st.rValid;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      st          <= '0;
      st.ctrl     <= MCTRL_RESET;
      st.sleeping <= 1'b1;
      st.rxMeta   <= 1'b1;
      st.rxSync   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready         = st.awRdy;
  assign s_axi_wready          = st.wRdy;
  assign s_axi_bvalid          = st.bValid;
  assign s_axi_bresp           = st.bResp;
  assign s_axi_arready         = st.arRdy;
  assign s_axi_rvalid          = st.rValid;
  assign s_axi_rdata           = st.rData;
  assign s_axi_rresp           = st.rResp;
  assign timeTrigEnable        = st.ctrl[BIT_TTEN];
  assign noRetryOnFail         = st.ctrl[BIT_NORETRY];
  assign overflowDiscardSelect = st.ctrl[BIT_DISCARD];
  assign txOrderSelect         = st.ctrl[BIT_TXORDER];
  assign prohibitTxDebug       = st.ctrl[BIT_PTD];
  assign sleepMode             = st.sleeping;
  assign freezeMode            = st.frozen;
  assign busOff                = st.busOff;
  assign rxFifoReset           = st.fifoRst;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_partial_soft_reset_sleep;
    commit && wrOk && st.awAddr == MASTER_CTRL && st.wData[BIT_PARTIAL_SOFT_RESET]
      |=> st.ctrl == MCTRL_RESET && rxFifoReset ##1 !rxFifoReset;
  endproperty
  a_partial_soft_reset_sleep: assert property (p_partial_soft_reset_sleep)
    else $error("partial reset did not restore control");

  property p_freeze_idle;
    $rose(freezeMode) |-> $past(!busActive) && $past(st.ctrl[BIT_FREEZE]);
  endproperty
  a_freeze_idle: assert property (p_freeze_idle)
    else $error("freeze entered during bus activity");

  property p_freeze_exit;
    $fell(freezeMode) |-> $past(run11) && $past(!st.ctrl[BIT_FREEZE]);
  endproperty
  a_freeze_exit: assert property (p_freeze_exit)
    else $error("freeze left without recessive run");

  property p_busoff_exit;
    $fell(busOff) |-> $past(st.occCnt) == OCC_LAST && $past(run11);
  endproperty
  a_busoff_exit: assert property (p_busoff_exit)
    else $error("bus-off left before 128 runs");

  property p_manual_rec;
    $fell(busOff) && $past(!st.ctrl[BIT_AUTOREC]) |-> $past(st.recArmed);
  endproperty
  a_manual_rec: assert property (p_manual_rec)
    else $error("bus-off left without freeze cycle");

  property p_auto_wake;
    sleepMode && st.ctrl[BIT_AUTOWAKE] && frameStart |=> !sleepMode;
  endproperty
  a_auto_wake: assert property (p_auto_wake)
    else $error("auto wake missed");

  property p_hold_sleep;
    sleepMode && !st.ctrl[BIT_AUTOWAKE] && !commit |=> sleepMode;
  endproperty
  a_hold_sleep: assert property (p_hold_sleep)
    else $error("sleep left without software");

  property p_noretry_write;
    commit && wrOk && st.awAddr == MASTER_CTRL && !st.wData[BIT_PARTIAL_SOFT_RESET]
      |=> noRetryOnFail == $past(st.wData[BIT_NORETRY]);
  endproperty
  a_noretry_write: assert property (p_noretry_write)
    else $error("retry select not written");

  property p_confirm_status;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == MODE_STATUS
      |=> s_axi_rdata[STS_FREEZE] == $past(freezeMode);
  endproperty
  a_confirm_status: assert property (p_confirm_status)
    else $error("freeze confirm misreported");

  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");

  c_freeze: cover property ($rose(freezeMode));
  c_recover: cover property ($fell(busOff));
  c_wake: cover property ($fell(sleepMode) && !commit);
  c_partial_soft_reset: cover property (rxFifoReset);
endmodule : cmc_mode_ctrl

`default_nettype wire

// File: cmc_can_node.sv
// Purpose: other nodes on the CAN bus, seen from canRx
// Assumes: bus idles recessive (high) between frames
// Notes:   timing in bit times of BIT_CYCLES clocks
`timescale 1ns/1ps
`default_nettype none
module cmc_can_node #(
  parameter int BIT_CYCLES = 2
) (
  // clock
  input  wire logic mclk,
  // bus view
  output var  logic canRx,
  output var  logic busActive,
  output var  logic frameStart
);
  initial begin
    canRx      = 1'b1;
    busActive  = 1'b0;
    frameStart = 1'b0;
  end
  // ****************
  // bus traffic
  // ****************
  task automatic bits(input logic lvl, input int n);
    repeat (n * BIT_CYCLES) begin
      @(posedge mclk);
      canRx <= lvl;
    end
  endtask : bits
  // dominant bit first so no partial run carries over
  task automatic runs(input int n);
    repeat (n) begin
      bits(1'b0, 1);
      bits(1'b1, 11);
    end
  endtask : runs
  task automatic busy(input logic b);
    @(posedge mclk);
    busActive <= b;
  endtask : busy
  task automatic frame();
    @(posedge mclk);
    frameStart <= 1'b1;
    busActive  <= 1'b1;
    canRx      <= 1'b0;
    @(posedge mclk);
    frameStart <= 1'b0;
    bits(1'b0, 2);
    bits(1'b1, 1);
    busActive  <= 1'b0;
  endtask : frame
endmodule : cmc_can_node
`default_nettype wire

// File: cmc_mode_ctrl_bench.sv
// Purpose: self-checking bench for cmc_mode_ctrl
// Assumes: BIT_CYCLES of 2 keeps bus-off recovery short
// Notes:   outputs sampled on the falling edge, settled
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_ctrl_bench;
  import cmc_pkg::*;
  localparam int BC = 2;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] awAddr = '0;
  logic [11:0] arAddr = '0;
  logic [31:0] wData = '0;
  logic [31:0] rData;
  logic [3:0]  wStrb = '0;
  logic [1:0]  bResp, rResp;
  logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0;
  logic        rReady = 0, busOffEnter = 0;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic        canRx, busActive, frameStart, ttEn, noRetry, discSel;
  logic        ordSel, ptd, sleepMode, freezeMode, busOff, rxFifoReset;
  int          miscompares = 0;
  int          nChecks = 0;
  int          pulses = 0;
  always #10 mclk = ~mclk;
  always @(negedge mclk) if (rxFifoReset === 1'b1) pulses++;
  cmc_mode_ctrl #(.BIT_CYCLES(BC)) dut (.mclk(mclk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .canRx(canRx), .busActive(busActive), .busOffEnter(busOffEnter),
    .frameStart(frameStart), .timeTrigEnable(ttEn),
    .noRetryOnFail(noRetry), .overflowDiscardSelect(discSel),
    .txOrderSelect(ordSel), .prohibitTxDebug(ptd), .sleepMode(sleepMode),
    .freezeMode(freezeMode), .busOff(busOff), .rxFifoReset(rxFifoReset));
  cmc_can_node #(.BIT_CYCLES(BC)) node (.mclk(mclk), .canRx(canRx),
    .busActive(busActive), .frameStart(frameStart));
  // ****************
  // bus and check tasks
  // ****************
  // handshakes judged on the falling edge, acted on at the rising one
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge mclk);
    awAddr  <= a;
    wData   <= d;
    wStrb   <= s;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    do begin
      @(negedge mclk);
      ta = awValid && awReady;
      tw = wValid && wReady;
      tb = bValid;
      r  = bResp;
      @(posedge mclk);
      if (ta) awValid <= 1'b0;
      if (tw) wValid <= 1'b0;
    end while (tb !== 1'b1);
    bReady <= 1'b0;
  endtask : axiWrite
  task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
                         output logic [1:0] r);
    logic ta, tr;
    @(posedge mclk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do begin
      @(negedge mclk);
      ta = arValid && arReady;
      tr = rValid;
      d  = rData;
      r  = rResp;
      @(posedge mclk);
      if (ta) arValid <= 1'b0;
    end while (tr !== 1'b1);
    rReady <= 1'b0;
  endtask : axiRead
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdChk(input logic [11:0] a, input logic [31:0] e,
                       input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask : rdChk
  task automatic wrChk(input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er);
    logic [1:0] r;
    axiWrite(MASTER_CTRL, d, s, r);
    chk(32'(r), 32'(er));
  endtask : wrChk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : cyc
  function automatic logic [31:0] modes();
    return {23'h0, ttEn, noRetry, discSel, ordSel, ptd, sleepMode,
            freezeMode, busOff, rxFifoReset};
  endfunction : modes
  task automatic offPulse();
    @(posedge mclk);
    busOffEnter <= 1'b1;
    @(posedge mclk);
    busOffEnter <= 1'b0;
  endtask : offPulse
  task automatic giveVerdict();
    if (miscompares == 0 && nChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : giveVerdict
  // ****************
  // scenarios
  // ****************
  task automatic tBits();
    chk(modes(), 32'h18);
    rdChk(MASTER_CTRL, MCTRL_RESET, RESP_OKAY);
    rdChk(MODE_STATUS, 32'h0a, RESP_OKAY);
    wrChk(32'h0001_009c, 4'hf, RESP_OKAY);
    cyc(2);
    chk(modes(), 32'h1f0);
    wrChk(32'h0, 4'h3, RESP_SLVERR);
    rdChk(MASTER_CTRL, 32'h0001_009c, RESP_OKAY);
    rdChk(12'h010, 32'h0, RESP_SLVERR);
    wrChk(32'h0, 4'hf, RESP_OKAY);
    cyc(2);
    chk(modes(), 32'h0);
  endtask : tBits
  task automatic tFreeze();
    node.busy(1'b1);
    wrChk(32'h1, 4'hf, RESP_OKAY);
    cyc(8);
    chk(32'(freezeMode), 32'h0);
    node.busy(1'b0);
    cyc(3);
    chk(32'(freezeMode), 32'h1);
    rdChk(MODE_STATUS, 32'h9, RESP_OKAY);
    fork
      node.bits(1'b0, 20);
      wrChk(32'h0, 4'hf, RESP_OKAY);
    join
    cyc(0);
    chk(32'(freezeMode), 32'h1);
    node.bits(1'b1, 10);
    cyc(0);
    chk(32'(freezeMode), 32'h1);
    node.bits(1'b1, 1);
    cyc(4);
    chk(32'(freezeMode), 32'h0);
  endtask : tFreeze
  task automatic tRecover(input logic autoRec);
    wrChk({25'h0, autoRec, 6'h0}, 4'hf, RESP_OKAY);
    // dominant bus while bus-off starts, so no idle run is counted early
    node.bits(1'b0, 2);
    offPulse();
    cyc(2);
    chk(32'(busOff), 32'h1);
    if (!autoRec) begin
      node.runs(128);
      cyc(6);
      chk(32'(busOff), 32'h1);
      wrChk(32'h1, 4'hf, RESP_OKAY);
      cyc(3);
      wrChk(32'h0, 4'hf, RESP_OKAY);
      node.bits(1'b1, 12);
    end
    node.runs(127);
    cyc(6);
    chk(32'(busOff), 32'h1);
    node.runs(1);
    cyc(6);
    chk(32'(busOff), 32'h0);
  endtask : tRecover
  task automatic tSleep();
    wrChk(32'h2, 4'hf, RESP_OKAY);
    node.frame();
    cyc(2);
    chk(32'(sleepMode), 32'h1);
    rdChk(MASTER_CTRL, 32'h2, RESP_OKAY);
    wrChk(32'h0, 4'hf, RESP_OKAY);
    cyc(2);
    chk(32'(sleepMode), 32'h0);
    wrChk(32'h22, 4'hf, RESP_OKAY);
    cyc(2);
    chk(32'(sleepMode), 32'h1);
    node.frame();
    cyc(1);
    chk(32'(sleepMode), 32'h0);
    rdChk(MASTER_CTRL, 32'h20, RESP_OKAY);
  endtask : tSleep
  task automatic tPartial();
    wrChk(32'h9c, 4'hf, RESP_OKAY);
    pulses = 0;
    wrChk(32'h8000, 4'hf, RESP_OKAY);
    cyc(2);
    chk(32'(pulses), 32'h1);
    chk(modes(), 32'h18);
    rdChk(MASTER_CTRL, MCTRL_RESET, RESP_OKAY);
  endtask : tPartial
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    cyc(2);
    tBits();
    tFreeze();
    tRecover(1'b1);
    tRecover(1'b0);
    tSleep();
    tPartial();
    giveVerdict();
  end
  // recovery runs dominate, about 10k clocks in all
  initial begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    giveVerdict();
  end
endmodule : cmc_mode_ctrl_bench
`default_nettype wire
